// >>> common/flash_host_pkg.sv
// Constants, types and command tables for the flash host sequencer
package flash_host_pkg;

    localparam int CLK_PERIOD_NS = 10;
    // Least write strobe low time; rounded up to whole cycles
    localparam int T_WE_LOW_NS   = 50;
    localparam int WE_LOW_CYCLES =
        (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least wait from read enable to valid data; rounded up
    localparam int T_ACCESS_NS   = 120;
    localparam int ACCESS_CYCLES =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;

    localparam logic [4:0] WE_LAST   = 5'(WE_LOW_CYCLES - 1);
    localparam logic [4:0] READ_LAST = 5'(ACCESS_CYCLES + SYNC_STAGES - 1);

    localparam int ADDR_W = 17;
    localparam int LANES  = 4;

    localparam logic [7:0] CODE_UNLOCK1      = 8'hAA;
    localparam logic [7:0] CODE_UNLOCK2      = 8'h55;
    localparam logic [7:0] CODE_PROGRAM      = 8'hA0;
    localparam logic [7:0] CODE_ERASE_SETUP  = 8'h80;
    localparam logic [7:0] CODE_CHIP_ERASE   = 8'h10;
    localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CODE_RESET        = 8'hF0;

    localparam logic [16:0] ADDR_UNLOCK1 = 17'h05555;
    localparam logic [16:0] ADDR_UNLOCK2 = 17'h02AAA;
    localparam logic [16:0] ADDR_ANY     = 17'h00000;

    // Status bit positions inside each byte lane
    localparam int BIT_POLL    = 7;
    localparam int BIT_TOGGLE  = 6;
    localparam int BIT_TIMEOUT = 5;

    localparam logic [2:0] LAST_PROGRAM = 3'h3;
    localparam logic [2:0] LAST_ERASE   = 3'h5;
    localparam logic [2:0] LAST_RESET   = 3'h0;

    typedef enum logic [1:0] {
        CMD_PROGRAM,
        CMD_SECTOR_ERASE,
        CMD_CHIP_ERASE,
        CMD_RESET
    } cmd_type;

    typedef enum logic [1:0] {
        WIDTH_8,
        WIDTH_16,
        WIDTH_32
    } width_type;

    typedef struct packed {
        logic [16:0] address;
        logic [7:0]  code;
        logic        use_data;
    } step_type;

    typedef struct packed {
        cmd_type     cmd;
        width_type   width;
        logic        use_toggle;
        logic [16:0] address;
        logic [31:0] data;
    } request_type;

    function automatic logic [3:0] lane_mask(width_type w);
        if (w == WIDTH_8) begin
            return 4'h1;
        end else if (w == WIDTH_16) begin
            return 4'h3;
        end
        return 4'hF;
    endfunction

    function automatic logic [2:0] last_step(cmd_type c);
        if (c == CMD_PROGRAM) begin
            return LAST_PROGRAM;
        end else if (c == CMD_RESET) begin
            return LAST_RESET;
        end
        return LAST_ERASE;
    endfunction

    function automatic step_type step_of(cmd_type c, logic [2:0] idx,
                                         logic [16:0] target);
        step_type s;
        s = '{address: ADDR_UNLOCK1, code: CODE_UNLOCK1, use_data: 1'b0};
        if (c == CMD_RESET) begin
            s.address = ADDR_ANY;
            s.code    = CODE_RESET;
        end else if (idx == 3'h1 || idx == 3'h4) begin
            s.address = ADDR_UNLOCK2;
            s.code    = CODE_UNLOCK2;
        end else if (idx == 3'h2) begin
            s.code = (c == CMD_PROGRAM) ? CODE_PROGRAM : CODE_ERASE_SETUP;
        end else if (idx == 3'h3 && c == CMD_PROGRAM) begin
            s.address  = target;
            s.use_data = 1'b1;
        end else if (idx == 3'h5) begin
            s.address = (c == CMD_SECTOR_ERASE) ? target : ADDR_UNLOCK1;
            s.code    = (c == CMD_SECTOR_ERASE) ? CODE_SECTOR_ERASE
                                                : CODE_CHIP_ERASE;
        end
        return s;
    endfunction

endpackage

// >>> src/flash_write_guard_status_poll.sv
// Host sequencer issuing flash commands and polling for completion
`timescale 1ns/100ps

// Operation
// - Write only with selects, strobes low, read high
// - Program codes on every active byte lane
// - Erase command bytes on every active lane
// - Poll program address, sector, or any address
// - Recheck polling bit after timeout flag seen
// - Recheck toggle bit after timeout flag seen
// - Issue reset sequence after timeout failure
module flash_write_guard_status_poll (
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_I,
    input  wire logic        START_I,
    input  wire logic [1:0]  CMD_I,
    input  wire logic [1:0]  WIDTH_I,
    input  wire logic        USE_TOGGLE_I,
    input  wire logic [16:0] ADDR_I,
    input  wire logic [31:0] DATA_I,
    output logic             BUSY_O,
    output logic             DONE_O,
    output logic             FAIL_O,
    output logic [3:0]       LANE_SELECT_N_O,
    output logic [3:0]       LANE_WRITE_STROBE_N_O,
    output logic             READ_ENABLE_N_O,
    output logic [16:0]      ADDRESS_O,
    output logic [31:0]      DQ_O,
    output logic             DQ_OE_O,
    input  wire logic [31:0] DQ_I
);

    typedef enum {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_LOW,
        ST_WR_HOLD,
        ST_RD_WAIT,
        ST_EVAL
    } state_type;

    state_type                  state;
    flash_host_pkg::request_type req;
    flash_host_pkg::cmd_type    active_cmd;
    flash_host_pkg::step_type   next_step;
    logic [2:0]                 step;
    logic [4:0]                 count;
    logic                       failing;
    logic                       recheck;
    logic                       have_prev;
    logic [31:0]                dq_meta;
    logic [31:0]                dq_sync;
    logic [31:0]                rd_data;
    logic [31:0]                prev_data;
    logic [3:0]                 mask;
    logic [3:0]                 lane_done;
    logic [3:0]                 lane_tmo;
    logic                       all_done;
    logic                       any_tmo;
    logic [16:0]                poll_target_address;
    logic                       seq_end;

    assign mask      = flash_host_pkg::lane_mask(req.width);
    assign next_step = flash_host_pkg::step_of(active_cmd, step + 3'h1,
                                               req.address);
    assign seq_end   = (step == flash_host_pkg::last_step(active_cmd));

    // Chip erase may poll anywhere
    always_comb begin
        if (req.cmd == flash_host_pkg::CMD_CHIP_ERASE) begin
            poll_target_address = flash_host_pkg::ADDR_ANY;
        end else begin
            poll_target_address = req.address;
        end
    end

    // Each lane reports on its own status bits
    genvar lane;
    generate
        for (lane = 0; lane < flash_host_pkg::LANES; lane++) begin : g_lane
            logic [7:0] cur;
            logic [7:0] old;
            logic       expect_poll;
            assign cur = rd_data[8*lane +: 8];
            assign old = prev_data[8*lane +: 8];
            // Erase ends with the polling bit at one
            assign expect_poll = (req.cmd == flash_host_pkg::CMD_PROGRAM)
                ? req.data[8*lane + flash_host_pkg::BIT_POLL] : 1'b1;
            assign lane_done[lane] = !mask[lane] || (req.use_toggle
                ? (have_prev && cur[flash_host_pkg::BIT_TOGGLE]
                                == old[flash_host_pkg::BIT_TOGGLE])
                : (cur[flash_host_pkg::BIT_POLL] == expect_poll));
            assign lane_tmo[lane] = mask[lane]
                && cur[flash_host_pkg::BIT_TIMEOUT];
        end
    endgenerate

    assign all_done = &lane_done;
    assign any_tmo  = |(lane_tmo & ~lane_done);

    // Pin data crosses in through two flip-flops
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            dq_meta <= 32'h00000000;
            dq_sync <= 32'h00000000;
        end else begin
            dq_meta <= DQ_I;
            dq_sync <= dq_meta;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state                 <= ST_IDLE;
            req                   <= '0;
            active_cmd            <= flash_host_pkg::CMD_PROGRAM;
            step                  <= 3'h0;
            count                 <= 5'h00;
            failing               <= 1'b0;
            recheck               <= 1'b0;
            have_prev             <= 1'b0;
            rd_data               <= 32'h00000000;
            prev_data             <= 32'h00000000;
            LANE_SELECT_N_O       <= 4'hF;
            LANE_WRITE_STROBE_N_O <= 4'hF;
            READ_ENABLE_N_O       <= 1'b1;
            ADDRESS_O             <= 17'h00000;
            DQ_O                  <= 32'h00000000;
            DQ_OE_O               <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (START_I) begin
                        req.cmd        <= flash_host_pkg::cmd_type'(CMD_I);
                        req.width      <= flash_host_pkg::width_type'(WIDTH_I);
                        req.use_toggle <= USE_TOGGLE_I;
                        req.address    <= ADDR_I;
                        req.data       <= DATA_I;
                        active_cmd     <= flash_host_pkg::cmd_type'(CMD_I);
                        step           <= 3'h7;
                        failing        <= 1'b0;
                        recheck        <= 1'b0;
                        have_prev      <= 1'b0;
                        state          <= ST_WR_HOLD;
                    end
                end
                ST_WR_SETUP: begin
                    // Read stays high through every write
                    READ_ENABLE_N_O       <= 1'b1;
                    LANE_SELECT_N_O       <= ~mask;
                    LANE_WRITE_STROBE_N_O <= ~mask;
                    count                 <= 5'h00;
                    state                 <= ST_WR_LOW;
                end
                ST_WR_LOW: begin
                    count <= count + 5'h01;
                    if (count == flash_host_pkg::WE_LAST) begin
                        LANE_WRITE_STROBE_N_O <= 4'hF;
                        LANE_SELECT_N_O       <= 4'hF;
                        state                 <= ST_WR_HOLD;
                    end
                end
                ST_WR_HOLD: begin
                    // Start also lands here with step wrapped to seven
                    DQ_OE_O <= 1'b0;
                    if (step == 3'h7 || !seq_end) begin
                        step      <= step + 3'h1;
                        ADDRESS_O <= next_step.address;
                        DQ_O      <= next_step.use_data ? req.data
                                     : {4{next_step.code}};
                        DQ_OE_O   <= 1'b1;
                        state     <= ST_WR_SETUP;
                    end else if (active_cmd == flash_host_pkg::CMD_RESET) begin
                        state <= ST_IDLE;
                    end else begin
                        ADDRESS_O       <= poll_target_address;
                        LANE_SELECT_N_O <= ~mask;
                        READ_ENABLE_N_O <= 1'b0;
                        count           <= 5'h00;
                        state           <= ST_RD_WAIT;
                    end
                end
                ST_RD_WAIT: begin
                    count <= count + 5'h01;
                    if (count == flash_host_pkg::READ_LAST) begin
                        rd_data         <= dq_sync;
                        prev_data       <= rd_data;
                        // Deselect between reads so the toggle bit advances
                        LANE_SELECT_N_O <= 4'hF;
                        READ_ENABLE_N_O <= 1'b1;
                        state           <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    have_prev <= 1'b1;
                    if (all_done) begin
                        state <= ST_IDLE;
                    end else if (recheck && have_prev) begin
                        // Still not done once the recheck reads are in
                        failing    <= 1'b1;
                        active_cmd <= flash_host_pkg::CMD_RESET;
                        step       <= 3'h7;
                        state      <= ST_WR_HOLD;
                    end else begin
                        recheck         <= recheck || any_tmo;
                        // Toggle state needs two reads after the flag
                        if (any_tmo && !recheck && req.use_toggle) begin
                            have_prev <= 1'b0;
                        end
                        ADDRESS_O       <= poll_target_address;
                        LANE_SELECT_N_O <= ~mask;
                        READ_ENABLE_N_O <= 1'b0;
                        count           <= 5'h00;
                        state           <= ST_RD_WAIT;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            FAIL_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            if (state == ST_IDLE && START_I) begin
                BUSY_O <= 1'b1;
                FAIL_O <= 1'b0;
            end else if (state == ST_EVAL && all_done) begin
                BUSY_O <= 1'b0;
                DONE_O <= 1'b1;
            end else if (state == ST_WR_HOLD && step != 3'h7 && seq_end
                         && active_cmd == flash_host_pkg::CMD_RESET) begin
                BUSY_O <= 1'b0;
                DONE_O <= 1'b1;
                FAIL_O <= failing;
            end
        end
    end

endmodule // flash_write_guard_status_poll

// >>> verification/flash_guard_checker.sv
// Concurrent checks on the flash host sequencer pins
`timescale 1ns/100ps
module flash_guard_checker (
    input wire logic        CLOCK_I,
    input wire logic        RESET_I,
    input wire logic        START_I,
    input wire logic        BUSY_O,
    input wire logic        DONE_O,
    input wire logic        FAIL_O,
    input wire logic [3:0]  LANE_SELECT_N_O,
    input wire logic [3:0]  LANE_WRITE_STROBE_N_O,
    input wire logic        READ_ENABLE_N_O,
    input wire logic [16:0] ADDRESS_O,
    input wire logic [31:0] DQ_O,
    input wire logic        DQ_OE_O
);
    logic saw_reset;

    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    // Cleared per request so a stale reset write cannot excuse a failure
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || (START_I && !BUSY_O)) begin
            saw_reset <= 1'b0;
        end else if (!LANE_WRITE_STROBE_N_O[0]
                     && DQ_O[7:0] == flash_host_pkg::CODE_RESET) begin
            saw_reset <= 1'b1;
        end
    end

    sequence s_strobe_low;
        !LANE_WRITE_STROBE_N_O[0] [*5];
    endsequence
    sequence s_read_held;
        (!READ_ENABLE_N_O && $stable(ADDRESS_O)) [*8];
    endsequence

    a_write_gate: assert property (LANE_WRITE_STROBE_N_O != 4'hF |->
        READ_ENABLE_N_O && DQ_OE_O
        && LANE_WRITE_STROBE_N_O == LANE_SELECT_N_O)
        else $error("write strobe without proper gating");
    a_read_clean: assert property (!READ_ENABLE_N_O |->
        !DQ_OE_O && LANE_WRITE_STROBE_N_O == 4'hF)
        else $error("read overlaps a write");
    a_strobe_width: assert property ($fell(LANE_WRITE_STROBE_N_O[0]) |->
        s_strobe_low ##1 LANE_WRITE_STROBE_N_O[0])
        else $error("write strobe width wrong");
    a_unlock2_lanes: assert property (!LANE_WRITE_STROBE_N_O[0]
        && ADDRESS_O == flash_host_pkg::ADDR_UNLOCK2
        |-> DQ_O == {4{flash_host_pkg::CODE_UNLOCK2}})
        else $error("second unlock code not on every lane");
    a_unlock1_lanes: assert property (!LANE_WRITE_STROBE_N_O[0]
        && ADDRESS_O == flash_host_pkg::ADDR_UNLOCK1
        |-> DQ_O == {4{DQ_O[7:0]}})
        else $error("command code not on every lane");
    a_read_held: assert property ($fell(READ_ENABLE_N_O) |=> s_read_held)
        else $error("poll read not held");
    a_done_pulse: assert property (DONE_O |=> !DONE_O)
        else $error("done longer than one cycle");
    a_busy_ends_done: assert property ($fell(BUSY_O) |-> DONE_O)
        else $error("busy dropped without done");
    a_fail_has_reset: assert property (DONE_O && FAIL_O |-> saw_reset)
        else $error("failure reported without reset sequence");
endmodule // flash_guard_checker

// >>> verification/flash_model.sv
// Behavioural flash device answering the host sequencer's pins
`timescale 1ns/100ps
module flash_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        low_supply_i,
    input  wire logic [3:0]  wait_reads_i,
    input  wire logic        late_timeout_i,
    input  wire logic        hang_i,
    input  wire logic [3:0]  select_n_i,
    input  wire logic [3:0]  strobe_n_i,
    input  wire logic        read_n_i,
    input  wire logic [16:0] address_i,
    input  wire logic [31:0] dq_i,
    output logic [31:0]      dq_o,
    output logic [31:0]      mem_o,
    output logic [16:0]      rd_addr_o,
    output logic [3:0]       wr_sel_o,
    output logic [3:0]       resets_o,
    output logic             hung_o
);
    logic [3:0]  cnt;
    logic [3:0]  prev_sel;
    logic        prev_str, prev_rd, prog_next, armed, tog, erase;
    logic [31:0] rd, wdata;
    logic        timeout;
    // Sector wired as protected; the address split is a model choice
    localparam logic [4:0] PROT_SECTOR = 5'h1F;
    wire logic   guarded = address_i[16:12] == PROT_SECTOR
        && (prog_next || wdata[7:0] == 8'h30);
    wire logic   write_edge = armed && !low_supply_i && !prev_str
        && strobe_n_i[0] && prev_sel != 4'hF && prev_rd;
    wire logic   read_start = !read_n_i && prev_rd && select_n_i != 4'hF;

    assign timeout = hung_o || (late_timeout_i && cnt == 4'h1);
    // Released bus shows the inverse so a stale value cannot pass
    assign dq_o = (!read_n_i && select_n_i != 4'hF) ? rd : ~rd;

    always_ff @(posedge clk_i) begin
        prev_str <= strobe_n_i[0];
        prev_sel <= select_n_i;
        prev_rd  <= read_n_i;
        armed    <= armed || strobe_n_i == 4'hF;
        if (!strobe_n_i[0]) begin
            wdata <= dq_i;
        end
        if (reset_i || low_supply_i) begin
            cnt       <= 4'h0;
            prog_next <= 1'b0;
            hung_o    <= 1'b0;
            if (reset_i) begin
                armed    <= 1'b0;
                resets_o <= 4'h0;
                mem_o    <= 32'hFFFFFFFF;
            end
        end
        // Reads still answer under lockout; only writes are shut out
        if (reset_i) begin
            tog   <= 1'b0;
            erase <= 1'b0;
        end else if (write_edge) begin
            wr_sel_o  <= prev_sel;
            prog_next <= wdata[7:0] == 8'hA0 && !prog_next;
            if (!guarded && (prog_next || wdata[7:0] == 8'h10
                             || wdata[7:0] == 8'h30)) begin
                mem_o  <= prog_next ? wdata : 32'hFFFFFFFF;
                erase  <= !prog_next;
                cnt    <= wait_reads_i;
                hung_o <= hang_i;
            end else if (wdata[7:0] == 8'hF0) begin
                cnt      <= 4'h0;
                hung_o   <= 1'b0;
                resets_o <= resets_o + 4'h1;
            end
        end else if (read_start) begin
            rd_addr_o <= address_i;
            tog       <= !tog;
            rd        <= mem_o;
            if (cnt != 4'h0 || hung_o) begin
                for (int i = 0; i < 4; i++) begin
                    rd[8*i+:8] <= {!erase && !mem_o[8*i+7], !tog, timeout,
                                   mem_o[8*i+:5]};
                end
                cnt <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
            end
        end
    end
endmodule // flash_model

// >>> verification/tb_top.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/100ps
bind flash_write_guard_status_poll flash_guard_checker chk (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .START_I(START_I),
    .BUSY_O(BUSY_O), .DONE_O(DONE_O), .FAIL_O(FAIL_O),
    .LANE_SELECT_N_O(LANE_SELECT_N_O),
    .LANE_WRITE_STROBE_N_O(LANE_WRITE_STROBE_N_O),
    .READ_ENABLE_N_O(READ_ENABLE_N_O), .ADDRESS_O(ADDRESS_O),
    .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O));

module tb_top;
    logic        clk = 1'b0, rst = 1'b1, start = 1'b0, use_tog = 1'b0;
    logic [1:0]  cmd = 2'h0, width = 2'h0;
    logic [16:0] addr = 17'h00000, rd_addr, address;
    logic [31:0] data = 32'h0, dq_out, flash_q, mem;
    logic [3:0]  wait_reads = 4'h3, sel_n, str_n, wr_sel, resets, r0;
    logic        late = 1'b0, hang = 1'b0, busy, done, fail, rd_n, dq_oe;
    logic        hung, low = 1'b0;
    int          miscompares = 0, num_checks = 0;
    wire logic [31:0] bus = dq_oe ? dq_out : flash_q;

    always #5 clk = ~clk;

    flash_write_guard_status_poll dut (.CLOCK_I(clk), .RESET_I(rst),
        .START_I(start), .CMD_I(cmd), .WIDTH_I(width),
        .USE_TOGGLE_I(use_tog), .ADDR_I(addr), .DATA_I(data),
        .BUSY_O(busy), .DONE_O(done), .FAIL_O(fail),
        .LANE_SELECT_N_O(sel_n), .LANE_WRITE_STROBE_N_O(str_n),
        .READ_ENABLE_N_O(rd_n), .ADDRESS_O(address), .DQ_O(dq_out),
        .DQ_OE_O(dq_oe), .DQ_I(bus));
    flash_model far (.clk_i(clk), .reset_i(rst), .low_supply_i(low),
        .wait_reads_i(wait_reads), .late_timeout_i(late), .hang_i(hang),
        .select_n_i(sel_n), .strobe_n_i(str_n), .read_n_i(rd_n),
        .address_i(address), .dq_i(bus), .dq_o(flash_q), .mem_o(mem),
        .rd_addr_o(rd_addr), .wr_sel_o(wr_sel), .resets_o(resets),
        .hung_o(hung));

    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic run_op(input logic [1:0] c, w, input logic t,
                          input logic [16:0] a, input logic [31:0] d,
                          input logic exp_fail);
        int n;
        @(posedge clk);
        start   <= 1'b1;
        cmd     <= c;
        width   <= w;
        use_tog <= t;
        addr    <= a;
        data    <= d;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 4000);
        chk("done", 32'h1, done);
        chk("fail", exp_fail, fail);
    endtask

    task automatic t_program;
        run_op(2'h0, 2'h2, 1'b0, 17'h01234, 32'hA5C35A3C, 1'b0);
        chk("program data", 32'hA5C35A3C, mem);
        chk("poll address", 17'h01234, rd_addr);
        chk("write lanes", 4'h0, wr_sel);
        run_op(2'h0, 2'h1, 1'b1, 17'h00100, 32'h12341E7F, 1'b0);
        chk("program data", 32'h12341E7F, mem);
        chk("write lanes", 4'hC, wr_sel);
    endtask

    task automatic t_erase;
        run_op(2'h1, 2'h0, 1'b1, 17'h08000, 32'h0, 1'b0);
        chk("poll address", 17'h08000, rd_addr);
        chk("erased data", 32'hFFFFFFFF, mem);
        chk("write lanes", 4'hE, wr_sel);
        run_op(2'h2, 2'h2, 1'b0, 17'h01111, 32'h0, 1'b0);
        chk("poll address", 17'h00000, rd_addr);
    endtask

    task automatic t_timeout;
        late <= 1'b1;
        run_op(2'h0, 2'h2, 1'b0, 17'h00200, 32'h0F0F0F0F, 1'b0);
        run_op(2'h0, 2'h2, 1'b1, 17'h00204, 32'hC3C3C3C3, 1'b0);
        late <= 1'b0;
        hang <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            r0 = resets;
            run_op(2'h0, 2'h2, t[0], 17'h00300, 32'h3C3C3C3C, 1'b1);
            chk("hung", 32'h0, hung);
            chk("reset writes", r0 + 4'h1, resets);
        end
        hang <= 1'b0;
        r0 = resets;
        run_op(2'h3, 2'h2, 1'b0, 17'h00000, 32'h0, 1'b0);
        chk("reset writes", r0 + 4'h1, resets);
    endtask

    // Data keeps the stored polling bits so ignored writes still finish
    task automatic t_guard;
        run_op(2'h0, 2'h2, 1'b0, 17'h1F000, 32'h1C1C1C1C, 1'b0);
        chk("protected data", 32'h3C3C3C3C, mem);
        low <= 1'b1;
        run_op(2'h0, 2'h2, 1'b0, 17'h00400, 32'h0C0C0C0C, 1'b0);
        chk("lockout data", 32'h3C3C3C3C, mem);
        low <= 1'b0;
        run_op(2'h0, 2'h2, 1'b0, 17'h00400, 32'h0C0C0C0C, 1'b0);
        chk("program data", 32'h0C0C0C0C, mem);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_program;
        t_erase;
        t_timeout;
        t_guard;
        final_report;
    end

    // A dozen requests of about a hundred cycles or fewer each fit well inside this
    initial begin
        #400000;
        miscompares++;
        final_report;
    end
endmodule // tb_top
